// ===== ciaf_pkg.sv
package ciaf_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int unsigned NSRC      = 10;  // 3 pins, 4 keys, 3 peripheral lines
  localparam int unsigned NPIN      = 7;
  localparam int unsigned LVL_W     = 3;
  localparam int unsigned SRC_W     = 4;
  localparam int unsigned EVT_W     = 3;
  localparam int unsigned TRAP_W    = 6;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFF_FLAGS  = 8'h00;
  localparam logic [7:0] OFF_SAVED  = 8'h04;
  localparam logic [7:0] OFF_LEVELS = 8'h08;
  localparam logic [7:0] OFF_PEND   = 8'h0C;
  localparam logic [7:0] OFF_EVT    = 8'h10;
  localparam logic [7:0] OFF_MASK   = 8'h14;

  // ---------------------------------------------------------------------------
  // Field positions in the flag word
  // ---------------------------------------------------------------------------
  localparam int unsigned FLD_I     = 0;
  localparam int unsigned FLD_U     = 1;
  localparam int unsigned FLD_IPL   = 2;
  localparam int unsigned FLD_RSV   = 7;

  // Event bits
  localparam int unsigned EVT_ACK   = 0;
  localparam int unsigned EVT_TRAP  = 1;
  localparam int unsigned EVT_NMI   = 2;

  // ---------------------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------------------
  localparam logic [NPIN-1:0]       PIN_IDLE    = 7'h7F;
  localparam logic [NSRC*LVL_W-1:0] LEVELS_RST  = 30'h0000_0000;
  localparam logic [EVT_W-1:0]      EVT_RST     = 3'h0;
  localparam logic [EVT_W-1:0]      MASK_RST    = 3'h0;
  localparam logic [LVL_W-1:0]      IPL_RST     = 3'h0;
  localparam logic [LVL_W-1:0]      NMI_LEVEL   = 3'h7;
  localparam logic [SRC_W-1:0]      NMI_SRC     = 4'hF;
  localparam logic [TRAP_W-1:0]     TRAP_U_MAX  = 6'h1F;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic             i;
    logic             u;
    logic [LVL_W-1:0] processor_priority_level;
  } ciaf_flags_t;

  localparam ciaf_flags_t FLAGS_RST = '{i: 1'b0, u: 1'b0, processor_priority_level: IPL_RST};

  typedef struct packed {
    logic       ext_irq_pin_c;
    logic       ext_irq_pin_b;
    logic       ext_irq_pin_a;
    logic [3:0] key_wakeup_inputs;
  } ciaf_pins_t;

  typedef struct packed {
    logic             valid;
    logic [SRC_W-1:0] src;
    logic [LVL_W-1:0] level;
  } ciaf_ack_t;

endpackage : ciaf_pkg

// ===== ciaf_pin_sync.sv
`timescale 1ns/1ns

module ciaf_pin_sync (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // Raw pins and settled levels
  input  wire logic [ciaf_pkg::NPIN-1:0]  pins_in,
  output logic      [ciaf_pkg::NPIN-1:0]  pins_stable
);

  typedef struct packed {
    logic [ciaf_pkg::NPIN-1:0] s1;
    logic [ciaf_pkg::NPIN-1:0] s2;
    logic [ciaf_pkg::NPIN-1:0] s3;
    logic [ciaf_pkg::NPIN-1:0] stable;
  } ciaf_sync_st_t;

  ciaf_sync_st_t st_reg;
  ciaf_sync_st_t st_next;

  // Stage 1 feeds stage 2 only; a level counts once stages 2 and 3 agree
  always_comb begin
    st_next        = st_reg;
    st_next.s1     = pins_in;
    st_next.s2     = st_reg.s1;
    st_next.s3     = st_reg.s2;
    st_next.stable = (st_reg.s2 & st_reg.s3) | (st_reg.stable & (st_reg.s2 ^ st_reg.s3));
  end

  // Pins idle high, so reset to the idle level to avoid a false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{s1: ciaf_pkg::PIN_IDLE, s2: ciaf_pkg::PIN_IDLE,
                  s3: ciaf_pkg::PIN_IDLE, stable: ciaf_pkg::PIN_IDLE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins_stable = st_reg.stable;

endmodule : ciaf_pin_sync

// ===== ciaf_prio_pick.sv
`timescale 1ns/1ns

module ciaf_prio_pick (
  // Requests and their levels
  input  wire logic [ciaf_pkg::NSRC-1:0]                req,
  input  wire logic [ciaf_pkg::NSRC*ciaf_pkg::LVL_W-1:0] levels,
  // Winner
  output logic                                           found,
  output logic      [ciaf_pkg::SRC_W-1:0]                idx,
  output logic      [ciaf_pkg::LVL_W-1:0]                lvl
);

  // Highest level wins; on a tie the lower index stays ahead
  always_comb begin
    logic [ciaf_pkg::LVL_W-1:0] cand;
    cand  = '0;
    found = 1'b0;
    idx   = '0;
    lvl   = '0;
    for (int k = 0; k < ciaf_pkg::NSRC; k++) begin
      cand = levels[k*ciaf_pkg::LVL_W +: ciaf_pkg::LVL_W];
      if (req[k] && (!found || (cand > lvl))) begin
        found = 1'b1;
        idx   = ciaf_pkg::SRC_W'(k);
        lvl   = cand;
      end
    end
  end

endmodule : ciaf_prio_pick

// ===== ciaf_accept.sv
// Overview of operation
// RULE1: Enable flag zero masks all maskable requests.
// RULE2: Acknowledge clears the interrupt enable flag.
// RULE3: Stack select zero interrupt stack, one user.
// RULE4: Acknowledge or trap 0..31 clears stack select.
// RULE5: Priority level is three bits, 0 to 7.
// RULE6: Accept only strictly above current priority level.
// RULE7: Reserved flag bit: software writes zero.
// RULE8: Low reset input returns flags to reset.
// RULE9: Three irq pins, four key pins, separate sources.
// RULE10: Maskable needs enable and priority; NMI bypasses.
// RULE11: Acknowledge saves old flags, loads request level.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ns

module ciaf_accept (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Request sources
  input  wire ciaf_pkg::ciaf_pins_t          pins,
  input  wire logic [2:0]                    periph_req,
  input  wire logic                          nmi_req,
  // Software trap from the core
  input  wire logic                          trap_valid,
  input  wire logic [ciaf_pkg::TRAP_W-1:0]   trap_num,
  // Acceptance towards the core
  output ciaf_pkg::ciaf_ack_t                ack,
  output ciaf_pkg::ciaf_flags_t              flags,
  output logic                               use_user_sp,
  // Event interrupt
  output logic                               irq
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    ciaf_pkg::ciaf_flags_t                 flags;
    ciaf_pkg::ciaf_flags_t                 saved;
    logic [ciaf_pkg::NSRC*ciaf_pkg::LVL_W-1:0] levels;
    logic [ciaf_pkg::NPIN-1:0]             pend;
    logic [ciaf_pkg::NPIN-1:0]             pin_prev;
    logic                                  nmi_pend;
    logic                                  nmi_prev;
    logic [ciaf_pkg::EVT_W-1:0]            evt;
    logic [ciaf_pkg::EVT_W-1:0]            mask;
    logic [31:0]                           prdata;
    logic                                  pready;
    logic                                  pslverr;
    logic                                  irq;
    ciaf_pkg::ciaf_ack_t                   ack;
  } ciaf_st_t;

  ciaf_st_t st_reg;
  ciaf_st_t st_next;

  logic [ciaf_pkg::NPIN-1:0] pins_stable;
  logic                      pick_found;
  logic [ciaf_pkg::SRC_W-1:0] pick_idx;
  logic [ciaf_pkg::LVL_W-1:0] pick_lvl;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    return hit(a, ciaf_pkg::OFF_FLAGS) || hit(a, ciaf_pkg::OFF_SAVED) ||
           hit(a, ciaf_pkg::OFF_LEVELS) || hit(a, ciaf_pkg::OFF_PEND) ||
           hit(a, ciaf_pkg::OFF_EVT) || hit(a, ciaf_pkg::OFF_MASK);
  endfunction : mapped

  function automatic logic [31:0] flag_word(input ciaf_pkg::ciaf_flags_t f);
    logic [31:0] w;
    w = '0;
    w[ciaf_pkg::FLD_I] = f.i;
    w[ciaf_pkg::FLD_U] = f.u;
    w[ciaf_pkg::FLD_IPL +: ciaf_pkg::LVL_W] = f.processor_priority_level;
    return w;
  endfunction : flag_word

  // ---------------------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------------------
  ciaf_pin_sync u_sync (
    .pclk        (pclk),
    .presetn     (presetn),
    .pins_in     (pins),
    .pins_stable (pins_stable)
  );

  // Pin requests are latched, peripheral lines are levels
  ciaf_prio_pick u_pick (
    .req    ({periph_req, st_reg.pend}),
    .levels (st_reg.levels),
    .found  (pick_found),
    .idx    (pick_idx),
    .lvl    (pick_lvl)
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic                       access;
    logic                       wr_en;
    logic                       maskable_ok;
    logic                       take;
    logic                       trap_u;
    logic [ciaf_pkg::NPIN-1:0]  fell;
    logic [ciaf_pkg::NPIN-1:0]  clr;
    logic [ciaf_pkg::EVT_W-1:0] new_evt;
    logic [31:0]                rd;
    access      = 1'b0;
    wr_en       = 1'b0;
    maskable_ok = 1'b0;
    take        = 1'b0;
    trap_u      = 1'b0;
    fell        = '0;
    clr         = '0;
    new_evt     = '0;
    rd          = '0;
    st_next     = st_reg;

    // Bus: one wait state, write lands on the edge that sees pready
    access         = psel && penable && !st_reg.pready;
    wr_en          = psel && penable && st_reg.pready && pwrite && !st_reg.pslverr;
    st_next.pready = access;
    st_next.pslverr = access && !mapped(paddr);
    case (paddr)
      ciaf_pkg::OFF_FLAGS:  rd = flag_word(st_reg.flags); // Reserved bit reads 0 [RULE7]
      ciaf_pkg::OFF_SAVED:  rd = flag_word(st_reg.saved);
      ciaf_pkg::OFF_LEVELS: rd = 32'(st_reg.levels);
      ciaf_pkg::OFF_PEND:   rd = 32'({st_reg.nmi_pend, periph_req, st_reg.pend});
      ciaf_pkg::OFF_EVT:    rd = 32'(st_reg.evt);
      ciaf_pkg::OFF_MASK:   rd = 32'(st_reg.mask);
      default:              rd = '0;
    endcase
    st_next.prdata = (access && !pwrite) ? rd : '0;

    // Software writes; the reserved flag bit is dropped on write [RULE7]
    if (wr_en && hit(paddr, ciaf_pkg::OFF_FLAGS)) begin
      st_next.flags.i   = pwdata[ciaf_pkg::FLD_I];
      st_next.flags.u   = pwdata[ciaf_pkg::FLD_U];
      st_next.flags.processor_priority_level = pwdata[ciaf_pkg::FLD_IPL +: ciaf_pkg::LVL_W]; // [RULE5]
    end
    if (wr_en && hit(paddr, ciaf_pkg::OFF_LEVELS)) begin
      st_next.levels = pwdata[ciaf_pkg::NSRC*ciaf_pkg::LVL_W-1:0];
    end
    if (wr_en && hit(paddr, ciaf_pkg::OFF_MASK)) begin
      st_next.mask = pwdata[ciaf_pkg::EVT_W-1:0];
    end

    // Falling edges on each settled pin are separate sources [RULE9]
    fell             = st_reg.pin_prev & ~pins_stable;
    st_next.pin_prev = pins_stable;
    st_next.nmi_prev = nmi_req;

    // Acceptance: enable flag and strict priority together [RULE1] [RULE6] [RULE10]
    maskable_ok = st_reg.flags.i && pick_found && (pick_lvl > st_reg.flags.processor_priority_level);
    take        = st_reg.nmi_pend || maskable_ok;
    st_next.ack = '{valid: take, src: '0, level: '0};

    if (st_reg.nmi_pend) begin
      // Non-maskable path skips both checks [RULE10]
      st_next.ack.src   = ciaf_pkg::NMI_SRC;
      st_next.ack.level = ciaf_pkg::NMI_LEVEL;
    end else if (maskable_ok) begin
      st_next.ack.src   = pick_idx;
      st_next.ack.level = pick_lvl;
      if (pick_idx < ciaf_pkg::SRC_W'(ciaf_pkg::NPIN)) begin
        clr[pick_idx[2:0]] = 1'b1;
      end
    end

    // Acknowledge: save, clear I and U, load level [RULE2] [RULE4] [RULE11]
    trap_u = trap_valid && (trap_num <= ciaf_pkg::TRAP_U_MAX);
    if (take) begin
      st_next.saved     = st_reg.flags;
      st_next.flags.i   = 1'b0;
      st_next.flags.u   = 1'b0;
      st_next.flags.processor_priority_level = st_next.ack.level;
    end else if (trap_valid) begin
      st_next.saved = st_reg.flags;
      if (trap_u) begin
        st_next.flags.u = 1'b0; // Traps 0..31 move to the interrupt stack [RULE4]
      end
    end

    // A new edge in the clear cycle stays pending
    st_next.pend     = (st_reg.pend & ~clr) | fell;
    st_next.nmi_pend = (st_reg.nmi_pend && !take) || (nmi_req && !st_reg.nmi_prev);

    // Sticky events, write one to clear, set wins
    new_evt[ciaf_pkg::EVT_ACK]  = maskable_ok && !st_reg.nmi_pend;
    new_evt[ciaf_pkg::EVT_TRAP] = trap_valid;
    new_evt[ciaf_pkg::EVT_NMI]  = st_reg.nmi_pend;
    if (wr_en && hit(paddr, ciaf_pkg::OFF_EVT)) begin
      st_next.evt = st_reg.evt & ~pwdata[ciaf_pkg::EVT_W-1:0];
    end
    st_next.evt = st_next.evt | new_evt;
    st_next.irq = |(st_next.evt & st_next.mask);
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  // Reset from the low reset input clears every flag [RULE8]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{flags: ciaf_pkg::FLAGS_RST, saved: ciaf_pkg::FLAGS_RST,
                  levels: ciaf_pkg::LEVELS_RST, pend: '0,
                  pin_prev: ciaf_pkg::PIN_IDLE, nmi_pend: 1'b0,
                  nmi_prev: 1'b0, evt: ciaf_pkg::EVT_RST,
                  mask: ciaf_pkg::MASK_RST, prdata: '0, pready: 1'b0,
                  pslverr: 1'b0, irq: 1'b0, ack: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs, all straight from flops
  // ---------------------------------------------------------------------------
  assign prdata      = st_reg.prdata;
  assign pready      = st_reg.pready;
  assign pslverr     = st_reg.pslverr;
  assign ack         = st_reg.ack;
  assign flags       = st_reg.flags;
  assign use_user_sp = st_reg.flags.u; // One selects the user stack [RULE3]
  assign irq         = st_reg.irq;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Checks tied to the overview rules
  mask_block_a: assert property ((!st_reg.flags.i && !st_reg.nmi_pend) |=> !st_reg.ack.valid) // [RULE1]
    else $error("maskable request taken while disabled");
  ack_clears_i_a: assert property (st_reg.ack.valid |-> !st_reg.flags.i) // [RULE2]
    else $error("enable flag still set after acknowledge");
  stack_select_a: assert property (!(psel && penable && st_reg.pready && pwrite // [RULE3]
                                     && paddr == ciaf_pkg::OFF_FLAGS)
                                   |=> !$rose(use_user_sp))
    else $error("user stack selected without a flag write");
  trap_clears_u_a: assert property ((trap_valid && trap_num <= ciaf_pkg::TRAP_U_MAX) // [RULE4]
                                    |=> !st_reg.flags.u)
    else $error("low trap left user stack selected");
  ack_clears_u_a: assert property (st_reg.ack.valid |-> !st_reg.flags.u) // [RULE4]
    else $error("acknowledge left user stack selected");
  strict_prio_a: assert property ((st_reg.ack.valid // [RULE6]
                                   && st_reg.ack.src != ciaf_pkg::NMI_SRC)
                                  |-> st_reg.ack.level > $past(st_reg.flags.processor_priority_level))
    else $error("request accepted at or below current level");
  reserved_zero_a: assert property ((st_reg.pready && paddr == ciaf_pkg::OFF_FLAGS // [RULE7]
                                     && !pwrite) |-> !st_reg.prdata[ciaf_pkg::FLD_RSV])
    else $error("reserved flag bit read as one");
  pin_pending_a: assert property ($fell(pins_stable[0]) |=> st_reg.pend[0]) // [RULE9]
    else $error("pin edge not held pending");
  level_load_a: assert property (st_reg.ack.valid // [RULE5] [RULE11]
                                 |-> st_reg.flags.processor_priority_level == st_reg.ack.level
                                  && st_reg.saved == $past(st_reg.flags))
    else $error("acknowledge did not save flags or load level");
  nmi_bypass_a: assert property (st_reg.nmi_pend // [RULE10]
                                 |=> st_reg.ack.valid && st_reg.ack.src == ciaf_pkg::NMI_SRC)
    else $error("non-maskable request not taken next cycle");

  // A trap above the low range leaves the stack choice to software
  trap_keeps_u_a: assert property ((trap_valid && trap_num > ciaf_pkg::TRAP_U_MAX // [RULE4]
                                    && st_reg.flags.u
                                    && !(psel && penable && st_reg.pready && pwrite))
                                   |=> st_reg.ack.valid || st_reg.flags.u)
    else $error("high trap cleared the stack select flag");
  // After an acknowledge the next maskable one waits for software
  enable_block_a: assert property (st_reg.ack.valid // [RULE2]
                                   |=> !st_reg.ack.valid || st_reg.ack.src == ciaf_pkg::NMI_SRC)
    else $error("second maskable request taken without re-enable");
  // Event bits fall only through a one-to-clear write
  evt_sticky_a: assert property (!(psel && penable && st_reg.pready && pwrite
                                   && paddr == ciaf_pkg::OFF_EVT)
                                 |=> (st_reg.evt & $past(st_reg.evt)) == $past(st_reg.evt))
    else $error("event bit fell without a clear");

  // One wait state on every access
  bus_wait_a: assert property ((psel && penable && !st_reg.pready) |=> st_reg.pready ##1 !st_reg.pready)
    else $error("bus answer not a single cycle");

  // Main scenarios seen at least once
  maskable_ack_c: cover property (st_reg.ack.valid && st_reg.ack.src != ciaf_pkg::NMI_SRC);
  nmi_ack_c:      cover property (st_reg.ack.valid && st_reg.ack.src == ciaf_pkg::NMI_SRC);
  trap_c:         cover property (trap_valid && st_reg.flags.u);
  irq_c:          cover property ($rose(st_reg.irq));
  pend_held_c:    cover property (st_reg.flags.i && (st_reg.pend != '0) && !st_reg.ack.valid);

endmodule : ciaf_accept

// ===== ciaf_src_model.sv
`timescale 1ns/1ns

module ciaf_src_model (
  // Clock
  input  wire logic            pclk,
  // Request lines towards the block
  output ciaf_pkg::ciaf_pins_t pins,
  output logic [2:0]           periph_req,
  output logic                 nmi_req
);
  // ---------------------------------------------------------------------------
  // Line state
  // ---------------------------------------------------------------------------
  // Pins rest high so that only a real fall can count as a request
  logic [ciaf_pkg::NPIN-1:0] pin_r = ciaf_pkg::PIN_IDLE;
  logic [2:0]                per_r = 3'h0;
  logic                      nmi_r = 1'b0;

  // Every source drives a line of its own
  assign pins       = pin_r;
  assign periph_req = per_r;
  assign nmi_req    = nmi_r;

  // Assert one source: a pin falls, a peripheral line rises
  task automatic raise(input int k);
    @(posedge pclk);
    if (k < 7) pin_r[k] <= 1'b0;
    else per_r[k-7] <= 1'b1;
  endtask : raise

  // Return a source to rest
  task automatic drop(input int k);
    @(posedge pclk);
    if (k < 7) pin_r[k] <= 1'b1;
    else per_r[k-7] <= 1'b0;
  endtask : drop

  // One rising edge on the non-maskable line
  task automatic nmi_pulse();
    @(posedge pclk);
    nmi_r <= 1'b1;
    @(posedge pclk);
    nmi_r <= 1'b0;
  endtask : nmi_pulse
endmodule : ciaf_src_model

// ===== ciaf_accept_test.sv
`timescale 1ns/1ns

module ciaf_accept_test;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic                        pclk       = 1'b0;
  logic                        presetn    = 1'b0;
  logic                        psel       = 1'b0;
  logic                        penable    = 1'b0;
  logic                        pwrite     = 1'b0;
  logic [7:0]                  paddr      = 8'h00;
  logic [31:0]                 pwdata     = 32'h0000_0000;
  logic [31:0]                 prdata;
  logic                        pready;
  logic                        pslverr;
  ciaf_pkg::ciaf_pins_t        pins;
  logic [2:0]                  periph_req;
  logic                        nmi_req;
  logic                        trap_valid = 1'b0;
  logic [ciaf_pkg::TRAP_W-1:0] trap_num   = 6'h00;
  ciaf_pkg::ciaf_ack_t         ack;
  ciaf_pkg::ciaf_flags_t       flags;
  logic                        use_user_sp;
  logic                        irq;
  logic [31:0]                 rd;
  logic                        err;
  logic [29:0]                 lv;
  int                          n_errors   = 0;
  int                          n_compared = 0;

  always #5 pclk = ~pclk;

  ciaf_accept DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .periph_req(periph_req), .nmi_req(nmi_req),
    .trap_valid(trap_valid), .trap_num(trap_num), .ack(ack), .flags(flags),
    .use_user_sp(use_user_sp), .irq(irq));

  ciaf_src_model src_model (.pclk(pclk), .pins(pins), .periph_req(periph_req),
    .nmi_req(nmi_req));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // A wait that ran out of cycles ends the run
  task automatic bail(input string what);
    n_errors++;
    $display("[ERR] %s expected 1 seen 0", what);
    test_done();
  endtask : bail

  // APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) bail("pready");
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, rd, exp);
  endtask : rdchk

  function automatic logic [31:0] fw(input logic i, input logic u, input logic [2:0] p);
    return {27'h0, p, u, i};
  endfunction : fw

  // Flag port as {i,u,ipl}
  function automatic logic [31:0] fp(input logic i, input logic u, input logic [2:0] p);
    return {27'h0, i, u, p};
  endfunction : fp

  // Checks at once, as the acknowledge may follow the enabling write directly
  task automatic wait_ack(input logic [3:0] s, input logic [2:0] l);
    int n;
    n = 0;
    #1;
    while (ack.valid !== 1'b1 && n < 40) begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (ack.valid !== 1'b1) bail("ack.valid");
    chk("ack.src", {28'h0, ack.src}, {28'h0, s});
    chk("ack.level", {29'h0, ack.level}, {29'h0, l});
    @(posedge pclk);
  endtask : wait_ack

  task automatic no_ack(input int n);
    int seen;
    seen = 0;
    repeat (n) begin
      @(posedge pclk);
      #1;
      if (ack.valid === 1'b1) seen++;
    end
    chk("ack count", seen, 32'h0);
  endtask : no_ack

  task automatic trap(input logic [5:0] t);
    @(posedge pclk);
    trap_valid <= 1'b1;
    trap_num   <= t;
    @(posedge pclk);
    trap_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
  endtask : trap

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("flags", {27'h0, flags}, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    rdchk("FLAGS", ciaf_pkg::OFF_FLAGS, 32'h0);
    rdchk("EVT", ciaf_pkg::OFF_EVT, 32'h0);
    rdchk("MASK", ciaf_pkg::OFF_MASK, 32'h0);
    rdchk("unmapped", 8'h20, 32'h0);
    chk("pslverr", {31'h0, err}, 32'h1);
    for (int k = 0; k < 10; k++) lv[3*k +: 3] = 3'(k % 7 + 1);
    apb(1'b1, ciaf_pkg::OFF_LEVELS, {2'h0, lv});
    rdchk("LEVELS", ciaf_pkg::OFF_LEVELS, {2'h0, lv});
    $display("test reset done");
    // Source 4 at level 5: masked, then equal, then above the current level
    apb(1'b1, ciaf_pkg::OFF_FLAGS, fw(1'b0, 1'b1, 3'h4));
    src_model.raise(4);
    no_ack(12);
    chk("use_user_sp", {31'h0, use_user_sp}, 32'h1);
    rdchk("PEND", ciaf_pkg::OFF_PEND, 32'h10);
    apb(1'b1, ciaf_pkg::OFF_FLAGS, fw(1'b1, 1'b1, 3'h5));
    no_ack(12);
    apb(1'b1, ciaf_pkg::OFF_FLAGS, fw(1'b1, 1'b1, 3'h4));
    wait_ack(4'h4, 3'h5);
    chk("flags", {27'h0, flags}, fp(1'b0, 1'b0, 3'h5));
    chk("use_user_sp", {31'h0, use_user_sp}, 32'h0);
    rdchk("SAVED", ciaf_pkg::OFF_SAVED, fw(1'b1, 1'b1, 3'h4));
    src_model.drop(4);
    $display("test accept done");
    // Every source on its own, each at its table level
    for (int k = 0; k < 10; k++) begin
      apb(1'b1, ciaf_pkg::OFF_FLAGS, fw(1'b1, 1'b0, 3'h0));
      src_model.raise(k);
      wait_ack(4'(k), 3'(k % 7 + 1));
      src_model.drop(k);
    end
    $display("test sources done");
    // Event interrupt: masked, unmasked, cleared
    rdchk("EVT", ciaf_pkg::OFF_EVT, 32'h1);
    chk("irq", {31'h0, irq}, 32'h0);
    apb(1'b1, ciaf_pkg::OFF_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    #1;
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, ciaf_pkg::OFF_EVT, 32'h1);
    rdchk("EVT", ciaf_pkg::OFF_EVT, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("test irq done");
    // Non-maskable request taken with the enable flag low
    src_model.nmi_pulse();
    wait_ack(4'hF, 3'h7);
    chk("flags", {27'h0, flags}, fp(1'b0, 1'b0, 3'h7));
    // Traps above and at the top of the stack-clearing range
    apb(1'b1, ciaf_pkg::OFF_FLAGS, fw(1'b1, 1'b1, 3'h2));
    trap(6'h20);
    chk("use_user_sp", {31'h0, use_user_sp}, 32'h1);
    trap(6'h1F);
    chk("flags", {27'h0, flags}, fp(1'b1, 1'b0, 3'h2));
    rdchk("SAVED", ciaf_pkg::OFF_SAVED, fw(1'b1, 1'b1, 3'h2));
    rdchk("EVT", ciaf_pkg::OFF_EVT, 32'h6);
    $display("test trap done");
    // Reserved bit reads back as zero
    apb(1'b1, ciaf_pkg::OFF_FLAGS, 32'h80 | fw(1'b0, 1'b0, 3'h1));
    rdchk("FLAGS", ciaf_pkg::OFF_FLAGS, fw(1'b0, 1'b0, 3'h1));
    // Reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk("flags", {27'h0, flags}, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    rdchk("MASK", ciaf_pkg::OFF_MASK, 32'h0);
    $display("test reset again done");
    test_done();
  end
endmodule : ciaf_accept_test
